// File: hpdcg_params.svh
// constants for the halt power-down clock gating block
// assumes inclusion by bare name from the package and hpdcg_top
`ifndef HPDCG_PARAMS_SVH
`define HPDCG_PARAMS_SVH

// ----------------------------------------------------------------
// i/o port addresses
// ----------------------------------------------------------------
`define HPDCG_ADDR_SUP_CMD    8'hf8
`define HPDCG_ADDR_SUP_MASTER 8'hf9
`define HPDCG_ADDR_CFG_PTR    8'hf1
`define HPDCG_ADDR_CFG_DATA   8'hf0

// ----------------------------------------------------------------
// indirect register indices
// ----------------------------------------------------------------
`define HPDCG_IDX_WCR         4'h0
`define HPDCG_IDX_UPPER       4'h1
`define HPDCG_IDX_LOWER       4'h2

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define HPDCG_KEY_MODE        8'hdb
`define HPDCG_MODE_MSB        4
`define HPDCG_MODE_LSB        3
`define HPDCG_MASTER_RESET    8'h18
`define HPDCG_MASTER_RW_MASK  8'hf8
`define HPDCG_WCR_RESET       8'hc0
`define HPDCG_WCR_ACK_MSB     7
`define HPDCG_WCR_ACK_LSB     6
`define HPDCG_WCR_RTY_MSB     5
`define HPDCG_WCR_RTY_LSB     4
`define HPDCG_WCR_OPW_MSB     3
`define HPDCG_WCR_OPW_LSB     2
`define HPDCG_WCR_WS_MSB      1
`define HPDCG_WCR_WS_LSB      0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define HPDCG_FETCH_LAST      4'hf
`define HPDCG_OSC_SETTLE      16

`endif

// File: hpdcg_pkg.sv
// types shared by the halt power-down clock gating block
// assumes the params header is on the include path
package hpdcg_pkg;
    `include "hpdcg_params.svh"

    // ------------------------------------------------------------
    // power-down select encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        light_sleep_mode       = 2'b00,
        timer_alive_sleep_mode = 2'b01,
        full_stop_mode         = 2'b10,
        run_mode               = 2'b11
    } hpdcg_mode_type;

    // ------------------------------------------------------------
    // halt sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        st_run      = 2'b00,
        st_halted   = 2'b01,
        st_osc_wake = 2'b10,
        st_resume   = 2'b11
    } hpdcg_state_type;
endpackage

// File: hpdcg_clk_gate.sv
// clock enable generation and clock output divider for the halt block
// assumes mode comes from the supervision master register and gate controls from the halt sequencer
`timescale 1ns/10ps
module hpdcg_clk_gate
    import hpdcg_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire hpdcg_mode_type power_down_select,
    input  wire logic           gate_active,
    input  wire logic           osc_only,
    output logic                osc_run,
    output logic                cpu_clk_en,
    output logic                parallel_port_unit_clk_en,
    output logic                serial_port_unit_clk_en,
    output logic                counter_timer_unit_clk_en,
    output logic                supervision_timer_clk_en,
    output logic                clock_output_pin
);
    // ------------------------------------------------------------
    // next-value state
    // ------------------------------------------------------------
    logic next_osc;      // oscillator keeps running
    logic next_core;     // cpu, parallel, serial, supervision clocks
    logic next_tmr;      // counter-timer clock
    logic clock_output_pin_en;     // clock output keeps toggling
    logic next_clock_output_pin;   // divided clock output

    // gating decision from mode, halt and wake phase
    always_comb begin
        next_osc  = 1'b1;
        next_core = 1'b1;
        next_tmr  = 1'b1;
        clock_output_pin_en = 1'b1;
        if (osc_only) begin
            // oscillator restarts first, everything else waits
            next_core = 1'b0;
            next_tmr  = 1'b0;
            clock_output_pin_en = 1'b0;
        end else if (gate_active) begin
            case (power_down_select)
                run_mode: begin
                    next_osc = 1'b1;
                end
                light_sleep_mode: begin
                    next_core = 1'b0;
                    next_tmr  = 1'b0;
                    clock_output_pin_en = 1'b0;
                end
                timer_alive_sleep_mode: begin
                    next_core = 1'b0;
                end
                full_stop_mode: begin
                    next_osc  = 1'b0;
                    next_core = 1'b0;
                    next_tmr  = 1'b0;
                    clock_output_pin_en = 1'b0;
                end
                default: begin
                    next_osc = 1'b1;
                end
            endcase
        end
        // a stopped output finishes its high phase and parks low
        next_clock_output_pin = clock_output_pin_en ? ~clock_output_pin : 1'b0;
    end

    // register the enables and the divided output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_run                   <= 1'b1;
            cpu_clk_en                <= 1'b1;
            parallel_port_unit_clk_en <= 1'b1;
            serial_port_unit_clk_en   <= 1'b1;
            counter_timer_unit_clk_en <= 1'b1;
            supervision_timer_clk_en  <= 1'b1;
            clock_output_pin          <= 1'b0;
        end else begin
            osc_run                   <= next_osc;
            cpu_clk_en                <= next_core;
            parallel_port_unit_clk_en <= next_core;
            serial_port_unit_clk_en   <= next_core;
            counter_timer_unit_clk_en <= next_tmr;
            supervision_timer_clk_en  <= next_core;
            clock_output_pin          <= next_clock_output_pin;
        end
    end
endmodule

// File: hpdcg_top.sv
// halt power-down clock control with system configuration registers
// assumes the cpu core drives one-cycle i/o strobes synchronous to ref_clk
`timescale 1ns/10ps
`include "hpdcg_params.svh"
module hpdcg_top
    import hpdcg_pkg::*;
#(
    parameter int OSC_SETTLE_CYCLES = `HPDCG_OSC_SETTLE
)(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    output logic      [7:0]  io_rdata,
    input  wire logic        opcode_fetch_strobe,
    input  wire logic        fourth_bus_state,
    input  wire logic        halt_fetch,
    input  wire logic        wake_event,
    input  wire logic        intack_cycle,
    input  wire logic        retry_cycle,
    input  wire logic        opcode_receive,
    input  wire logic [15:0] mem_addr,
    output logic             halt_n,
    output logic             nop_force,
    output logic             ack_stall,
    output logic             wait_req,
    output logic             mem_wait_hit,
    output logic             osc_run,
    output logic             cpu_clk_en,
    output logic             parallel_port_unit_clk_en,
    output logic             serial_port_unit_clk_en,
    output logic             counter_timer_unit_clk_en,
    output logic             supervision_timer_clk_en,
    output logic             clock_output_pin
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (OSC_SETTLE_CYCLES < 1 || OSC_SETTLE_CYCLES > 65535) begin : g_chk
        $error("oscillator settle count out of range");
    end

    localparam logic [15:0] SETTLE_LOAD = 16'(OSC_SETTLE_CYCLES - 1);

    // indirect register read mux, used for read-back of the data port
    function automatic logic [7:0] cfg_read(input logic [3:0] idx, input logic [7:0] wcr,
                                            input logic [7:0] upper, input logic [7:0] lower);
        case (idx)
            `HPDCG_IDX_WCR:   cfg_read = wcr;
            `HPDCG_IDX_UPPER: cfg_read = upper;
            `HPDCG_IDX_LOWER: cfg_read = lower;
            default:          cfg_read = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------
    logic [7:0] supervision_master_reg;      // enable, period, power-down select
    logic [7:0] next_supervision_master_reg;
    logic       key_armed;                   // key seen, next write may change mode
    logic       next_key_armed;
    logic [3:0] cfg_ptr;                     // indirect register pointer
    logic [3:0] next_cfg_ptr;
    logic [7:0] wait_state_ctrl;             // wait state control
    logic [7:0] next_wait_state_ctrl;
    logic [7:0] wait_upper;                  // upper boundary of wait region
    logic [7:0] next_wait_upper;
    logic [7:0] wait_lower;                  // lower boundary of wait region
    logic [7:0] next_wait_lower;
    logic       wcr_written;                 // software has programmed the wait field
    logic       next_wcr_written;
    logic [3:0] fetch_count;                 // trailing fetch strobes since reset
    logic [3:0] next_fetch_count;
    logic       fetch_q;                     // fetch strobe last cycle
    logic       fetch_done;                  // power-on wait window finished
    logic       next_fetch_done;
    logic [7:0] next_io_rdata;
    logic [7:0] wcr_view;                    // wait control as seen by reads
    logic       fetch_trail;                 // trailing edge of fetch strobe
    hpdcg_mode_type mode;                    // current power-down select

    assign mode = hpdcg_mode_type'(supervision_master_reg[`HPDCG_MODE_MSB:`HPDCG_MODE_LSB]);
    assign fetch_trail = fetch_q & ~opcode_fetch_strobe;

    // live cycle indications overlay the stored fields on read
    always_comb begin
        wcr_view = wait_state_ctrl;
        if (intack_cycle) begin
            wcr_view[`HPDCG_WCR_ACK_MSB:`HPDCG_WCR_ACK_LSB] = 2'b11;
        end
        if (retry_cycle) begin
            wcr_view[`HPDCG_WCR_RTY_MSB:`HPDCG_WCR_RTY_LSB] = 2'b11;
        end
        if (opcode_receive) begin
            wcr_view[`HPDCG_WCR_OPW_MSB:`HPDCG_WCR_OPW_LSB] = 2'b00;
        end
    end

    // register writes, key sequence, reads and power-on wait window
    always_comb begin
        next_supervision_master_reg = supervision_master_reg;
        next_key_armed              = key_armed;
        next_cfg_ptr                = cfg_ptr;
        next_wait_state_ctrl        = wait_state_ctrl;
        next_wait_upper             = wait_upper;
        next_wait_lower             = wait_lower;
        next_wcr_written            = wcr_written;
        next_fetch_count            = fetch_count;
        next_fetch_done             = fetch_done;
        next_io_rdata               = io_rdata;
        // count trailing fetch edges; clear bits 7-6 on the sixteenth if wcr_written is still low
        if (!fetch_done && fetch_trail) begin
            next_fetch_count = fetch_count + 4'h1;
            if (fetch_count == `HPDCG_FETCH_LAST) begin
                next_fetch_done = 1'b1;
                if (!wcr_written) begin
                    next_wait_state_ctrl[`HPDCG_WCR_ACK_MSB:`HPDCG_WCR_ACK_LSB] = 2'b00;
                end
            end
        end
        if (io_wr) begin
            // any write other than the key disarms the mode change
            next_key_armed = 1'b0;
            case (io_addr)
                `HPDCG_ADDR_SUP_CMD: begin
                    next_key_armed = (io_wdata == `HPDCG_KEY_MODE);
                end
                `HPDCG_ADDR_SUP_MASTER: begin
                    next_supervision_master_reg = (io_wdata & 8'he0)
                        | (supervision_master_reg & 8'h18);
                    if (key_armed) begin
                        next_supervision_master_reg = io_wdata & `HPDCG_MASTER_RW_MASK;
                    end
                end
                `HPDCG_ADDR_CFG_PTR: begin
                    if (io_wdata[7:4] == 4'h0) begin
                        next_cfg_ptr = io_wdata[3:0];
                    end
                end
                `HPDCG_ADDR_CFG_DATA: begin
                    case (cfg_ptr)
                        `HPDCG_IDX_WCR: begin
                            next_wait_state_ctrl = io_wdata;
                            next_wcr_written     = 1'b1;
                        end
                        `HPDCG_IDX_UPPER: next_wait_upper = io_wdata;
                        `HPDCG_IDX_LOWER: next_wait_lower = io_wdata;
                        default:          next_wait_lower = wait_lower;
                    endcase
                end
                default: next_cfg_ptr = cfg_ptr;
            endcase
        end
        if (io_rd) begin
            case (io_addr)
                `HPDCG_ADDR_SUP_MASTER: next_io_rdata = supervision_master_reg;
                `HPDCG_ADDR_CFG_PTR:    next_io_rdata = {4'h0, cfg_ptr};
                `HPDCG_ADDR_CFG_DATA:   next_io_rdata = cfg_read(cfg_ptr, wcr_view,
                                                                 wait_upper, wait_lower);
                default:                next_io_rdata = 8'h00;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            supervision_master_reg <= `HPDCG_MASTER_RESET;
            key_armed              <= 1'b0;
            cfg_ptr                <= 4'h0;
            wait_state_ctrl        <= `HPDCG_WCR_RESET;
            wait_upper             <= 8'h00;
            wait_lower             <= 8'h00;
            wcr_written            <= 1'b0;
            fetch_count            <= 4'h0;
            fetch_q                <= 1'b0;
            fetch_done             <= 1'b0;
            io_rdata               <= 8'h00;
        end else begin
            supervision_master_reg <= next_supervision_master_reg;
            key_armed              <= next_key_armed;
            cfg_ptr                <= next_cfg_ptr;
            wait_state_ctrl        <= next_wait_state_ctrl;
            wait_upper             <= next_wait_upper;
            wait_lower             <= next_wait_lower;
            wcr_written            <= next_wcr_written;
            fetch_count            <= next_fetch_count;
            fetch_q                <= opcode_fetch_strobe;
            fetch_done             <= next_fetch_done;
            io_rdata               <= next_io_rdata;
        end
    end

    // ------------------------------------------------------------
    // bus cycle stretching
    // ------------------------------------------------------------
    logic [1:0] retry_waits;      // wait states already inserted this retry
    logic [1:0] next_retry_waits;
    logic       next_ack_stall;
    logic       next_wait_req;
    logic       next_mem_wait_hit;

    // retry waits, acknowledge stall and region compare
    always_comb begin
        next_retry_waits = 2'b00;
        next_wait_req    = 1'b0;
        if (retry_cycle) begin
            next_retry_waits = retry_waits;
            if (retry_waits < wait_state_ctrl[`HPDCG_WCR_WS_MSB:`HPDCG_WCR_WS_LSB]) begin
                next_wait_req    = 1'b1;
                next_retry_waits = retry_waits + 2'b01;
            end
        end
        next_ack_stall = intack_cycle
            && (wait_state_ctrl[`HPDCG_WCR_ACK_MSB:`HPDCG_WCR_ACK_LSB] == 2'b01
             || wait_state_ctrl[`HPDCG_WCR_ACK_MSB:`HPDCG_WCR_ACK_LSB] == 2'b10);
        next_mem_wait_hit = (mem_addr[15:8] <= wait_upper)
                         && (mem_addr[15:8] >= wait_lower);
    end

    // stretch flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            retry_waits  <= 2'b00;
            ack_stall    <= 1'b0;
            wait_req     <= 1'b0;
            mem_wait_hit <= 1'b0;
        end else begin
            retry_waits  <= next_retry_waits;
            ack_stall    <= next_ack_stall;
            wait_req     <= next_wait_req;
            mem_wait_hit <= next_mem_wait_hit;
        end
    end

    // ------------------------------------------------------------
    // halt sequencer
    // ------------------------------------------------------------
    hpdcg_state_type state;       // halt sequencer state
    hpdcg_state_type next_state;
    logic [15:0]     settle;      // oscillator restart countdown
    logic [15:0]     next_settle;
    logic            next_halt_n;
    logic            gate_active; // mode gating in force
    logic            osc_only;    // only the oscillator may run

    // entry at the halt fetch, exit on wake, with oscillator restart after full stop only
    always_comb begin
        next_state  = state;
        next_settle = settle;
        next_halt_n = halt_n;
        case (state)
            st_run: begin
                if (halt_fetch && fourth_bus_state) begin
                    next_halt_n = 1'b0;
                    next_state  = st_halted;
                end
            end
            st_halted: begin
                if (wake_event) begin
                    if (mode == full_stop_mode) begin
                        next_state  = st_osc_wake;
                        next_settle = SETTLE_LOAD;
                    end else begin
                        next_state = st_resume;
                    end
                end
            end
            st_osc_wake: begin
                next_settle = settle - 16'h0001;
                if (settle == 16'h0000) begin
                    next_state = st_resume;
                end
            end
            st_resume: begin
                next_halt_n = 1'b1;
                next_state  = st_run;
            end
            default: next_state = st_run;
        endcase
    end

    // sequencer flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state  <= st_run;
            settle <= 16'h0000;
            halt_n <= 1'b1;
        end else begin
            state  <= next_state;
            settle <= next_settle;
            halt_n <= next_halt_n;
        end
    end

    // gating follows the registered halt state, one edge after halt_n
    assign gate_active = (state == st_halted);
    assign osc_only    = (state == st_osc_wake);
    // halted with a live cpu clock repeats no-op cycles
    assign nop_force   = ~halt_n & cpu_clk_en;

    // ------------------------------------------------------------
    // clock enables
    // ------------------------------------------------------------
    hpdcg_clk_gate u_gate (
        .ref_clk                   (ref_clk),
        .rst_n                     (rst_n),
        .power_down_select         (mode),
        .gate_active               (gate_active),
        .osc_only                  (osc_only),
        .osc_run                   (osc_run),
        .cpu_clk_en                (cpu_clk_en),
        .parallel_port_unit_clk_en (parallel_port_unit_clk_en),
        .serial_port_unit_clk_en   (serial_port_unit_clk_en),
        .counter_timer_unit_clk_en (counter_timer_unit_clk_en),
        .supervision_timer_clk_en  (supervision_timer_clk_en),
        .clock_output_pin          (clock_output_pin)
    );
endmodule

// File: hpdcg_cpu_model.sv
// cpu core stand-in: endless four-state opcode fetches while its clock runs
// assumes the bench raises want_halt when a halt opcode should be fetched
`timescale 1ns/10ps
module hpdcg_cpu_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic cpu_clk_en,
    input  wire logic want_halt,
    output logic      opcode_fetch_strobe,
    output logic      fourth_bus_state,
    output logic      halt_fetch
);
    logic [1:0] tstate; // bus state within the current fetch
    // a gated cpu clock freezes the fetch where it stands
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            tstate <= 2'h0;
        else if (cpu_clk_en)
            tstate <= tstate + 2'h1;
    end
    assign opcode_fetch_strobe = rst_n && !tstate[1];
    assign fourth_bus_state    = cpu_clk_en && tstate == 2'h3;
    assign halt_fetch          = want_halt && tstate == 2'h3;
endmodule

// File: hpdcg_top_sva.sv
// checker of the halt clock gating outputs of hpdcg_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module hpdcg_top_sva (
    input wire logic ref_clk, rst_n, halt_fetch, fourth_bus_state, intack_cycle,
    input wire logic retry_cycle, halt_n, nop_force, ack_stall, wait_req, osc_run,
    input wire logic cpu_clk_en, counter_timer_unit_clk_en, clock_output_pin
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [2:0] en = {osc_run, cpu_clk_en, counter_timer_unit_clk_en}; // osc, cpu, timer
    // halt opcode seen at the fourth state while running
    sequence s_halt_taken;
        halt_fetch && fourth_bus_state && halt_n && cpu_clk_en;
    endsequence
    a_halt_goes_low: assert property (s_halt_taken |=> !halt_n)
        else $error("halt indicator late");
    a_gate_waits: assert property ($fell(halt_n) |-> en == 3'b111)
        else $error("gating before halt indicator");
    a_gate_modes: assert property (!halt_n && !$fell(halt_n) |-> en inside {3'b111, 3'b100, 3'b101, 3'b000})
        else $error("illegal gating pattern");
    a_clk_parks: assert property (!counter_timer_unit_clk_en && !$past(counter_timer_unit_clk_en) |-> !clock_output_pin)
        else $error("clock output not parked low");
    a_clk_toggles: assert property (counter_timer_unit_clk_en && $past(counter_timer_unit_clk_en, 2) && $past(rst_n) |-> clock_output_pin != $past(clock_output_pin))
        else $error("clock output stalled");
    a_nop_in_halt: assert property (nop_force == (!halt_n && cpu_clk_en))
        else $error("no-op force wrong");
    a_osc_first: assert property ($rose(cpu_clk_en) |-> osc_run && $past(osc_run))
        else $error("cpu clock before oscillator");
    a_release_all: assert property ($rose(halt_n) |-> en == 3'b111)
        else $error("halt left with clocks gated");
    a_stall_cause: assert property (ack_stall |-> $past(intack_cycle))
        else $error("stall without acknowledge");
    a_retry_only: assert property (wait_req |-> $past(retry_cycle))
        else $error("wait outside retry");
endmodule
bind hpdcg_top hpdcg_top_sva u_hpdcg_top_sva (.ref_clk, .rst_n, .halt_fetch, .fourth_bus_state,
    .intack_cycle, .retry_cycle, .halt_n, .nop_force, .ack_stall, .wait_req, .osc_run,
    .cpu_clk_en, .counter_timer_unit_clk_en, .clock_output_pin);

// File: hpdcg_top_tb.sv
// self-checking bench for hpdcg_top with a cpu fetch model on its far side
// assumes the package, design, model and checker are compiled before it
`timescale 1ns/10ps
module hpdcg_top_tb;
    import hpdcg_pkg::*;
    logic ref_clk, rst_n, io_wr, io_rd, wake_event, intack_cycle, retry_cycle, c;
    logic opcode_receive, want_halt, halt_n, nop_force, ack_stall, wait_req, mem_wait_hit;
    logic opcode_fetch_strobe, fourth_bus_state, halt_fetch, clock_output_pin;
    logic [7:0]  io_addr, io_wdata, io_rdata, rd_val, lo, hi, v, cnt;
    logic [15:0] mem_addr;
    wire  [5:0]  en; // osc, cpu, parallel, serial, timer, supervision enables
    int          bad_count, checks_done, seed, n;
    hpdcg_top #(.OSC_SETTLE_CYCLES(2)) u_hpdcg_top (.ref_clk, .rst_n, .io_addr, .io_wdata,
        .io_wr, .io_rd, .io_rdata, .opcode_fetch_strobe, .fourth_bus_state, .halt_fetch,
        .wake_event, .intack_cycle, .retry_cycle, .opcode_receive, .mem_addr, .halt_n,
        .nop_force, .ack_stall, .wait_req, .mem_wait_hit, .osc_run(en[5]), .cpu_clk_en(en[4]),
        .parallel_port_unit_clk_en(en[3]), .serial_port_unit_clk_en(en[2]),
        .counter_timer_unit_clk_en(en[1]), .supervision_timer_clk_en(en[0]), .clock_output_pin);
    hpdcg_cpu_model u_hpdcg_cpu_model (.ref_clk, .rst_n, .cpu_clk_en(en[4]), .want_halt,
        .opcode_fetch_strobe, .fourth_bus_state, .halt_fetch);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task cyc;
        @(posedge ref_clk);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, then an idle cycle
    task wr(input logic [7:0] a, input logic [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        cyc;
        io_wr <= 1'b0;
        cyc;
    endtask
    task rd(input logic [7:0] a);
        io_addr <= a;
        io_rd <= 1'b1;
        cyc;
        io_rd <= 1'b0;
        cyc;
        #1 rd_val = io_rdata;
    endtask
    task wait_halt(input logic lvl);
        n = 0;
        while (halt_n !== lvl && n < 80) begin
            cyc;
            #1 n++;
        end
        chk({7'h0, halt_n}, {7'h0, lvl});
    endtask
    // enables expected while halted in each power-down mode
    function automatic logic [5:0] exp_gate(input logic [1:0] m);
        case (m)
            run_mode:               return 6'h3f;
            light_sleep_mode:       return 6'h20;
            timer_alive_sleep_mode: return 6'h22;
            default:                return 6'h00;
        endcase
    endfunction
    task end_of_test;
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        end_of_test;
    end
    initial begin
        {seed, bad_count, checks_done} = {32'd18872, 64'd0};
        {rst_n, io_wr, io_rd, wake_event, intack_cycle, retry_cycle, want_halt} = 7'h00;
        {io_addr, io_wdata, opcode_receive, mem_addr} = 33'h0;
        repeat (4) cyc;
        rst_n <= 1'b1;
        cyc;
        rd(8'hf0);
        chk(rd_val, 8'hc0);
        repeat (70) cyc;
        rd(8'hf0);
        chk(rd_val, 8'h00);
        v = 8'($random(seed));
        wr(8'hf0, v);
        {intack_cycle, retry_cycle, opcode_receive} <= 3'h7;
        rd(8'hf0);
        chk(rd_val, {4'hf, 2'h0, v[1:0]});
        {intack_cycle, retry_cycle, opcode_receive} <= 3'h0;
        for (int i = 0; i < 4; i++) begin
            wr(8'hf0, {i[1:0], 4'h0, i[1:0]});
            {intack_cycle, retry_cycle} <= 2'h3;
            cyc;
            intack_cycle <= 1'b0;
            cnt = 8'h00;
            #1 chk({7'h0, ack_stall}, {7'h0, i[0] ^ i[1]});
            repeat (6) begin
                cnt = cnt + {7'h0, wait_req};
                cyc;
                #1;
            end
            retry_cycle <= 1'b0;
            chk(cnt, 8'(i));
        end
        for (int i = 0; i < 6; i++) begin
            {lo, hi} = {8'($random(seed)), 8'($random(seed))};
            if (lo > hi)
                {lo, hi} = {hi, lo};
            wr(8'hf1, 8'h01);
            wr(8'hf0, hi);
            wr(8'hf1, 8'h02);
            wr(8'hf0, lo);
            mem_addr <= {(i == 0) ? lo : (i == 1) ? hi : 8'($random(seed)), 8'($random(seed))};
            cyc;
            cyc;
            #1 chk({7'h0, mem_wait_hit}, {7'h0, mem_addr[15:8] >= lo && mem_addr[15:8] <= hi});
        end
        wr(8'hf1, 8'h35);
        rd(8'hf1);
        chk(rd_val, 8'h02);
        wr(8'hf9, 8'h00);
        rd(8'hf9);
        chk(rd_val, 8'h18);
        for (int m = 0; m < 5; m++) begin
            wr(8'hf8, 8'hdb);
            wr(8'hf9, {3'h0, m[1:0] ^ {m[2], 1'b0}, 3'h0});
            want_halt <= 1'b1;
            wait_halt(1'b0);
            want_halt <= 1'b0;
            if (m == 4)
                break;
            repeat (3) cyc;
            #1 chk({2'h0, en}, {2'h0, exp_gate(m[1:0])});
            chk({7'h0, nop_force}, {7'h0, m == 3});
            c = clock_output_pin;
            cyc;
            #1 chk({6'h0, c ^ clock_output_pin, c & clock_output_pin}, {6'h0, m[0], 1'b0});
            wake_event <= 1'b1;
            cyc;
            wake_event <= 1'b0;
            wait_halt(1'b1);
            chk({2'h0, en}, 8'h3f);
        end
        rst_n <= 1'b0;
        repeat (4) cyc;
        rst_n <= 1'b1;
        cyc;
        rd(8'hf9);
        chk(rd_val, 8'h18);
        chk({2'h0, en}, 8'h3f);
        end_of_test;
    end
endmodule
